// >>> host_block_source.sv
`timescale 1ns/100ps
// ****************************************
// Host side, sends definite-length blocks
// ****************************************
module host_block_source
(
   input wire ref_clk,
   output reg [7:0] hostData,
   output reg hostStrobe,
   output reg hostEoi
);
   initial
   begin
      hostData = 8'h00;
      hostStrobe = 1'b0;
      hostEoi = 1'b0;
   end
   task automatic sendBlock(input logic [7:0] body[$]);
      string len;
      logic [7:0] all[$];
      begin
         len = $sformatf("%0d", body.size());
         all = {8'h23, 8'(8'h30 + len.len())};
         for (int i = 0; i < len.len(); i++)
            all.push_back(len[i]);
         all = {all, body};
         foreach (all[i])
         begin
            @(posedge ref_clk);
            hostStrobe <= 1'b1;
            hostData <= all[i];
            hostEoi <= (i == all.size() - 1);
         end
         @(posedge ref_clk);
         hostStrobe <= 1'b0;
         hostEoi <= 1'b0;
         // Released bus shows no stale byte
         hostData <= ~all[all.size() - 1];
      end
   endtask
endmodule

// >>> wave_loader_defines.vh
`ifndef WAVE_LOADER_DEFINES_VH
`define WAVE_LOADER_DEFINES_VH

// Register byte addresses
`define ADDR_CONTROL 8'h00
`define ADDR_SELECT 8'h04
`define ADDR_DEFINE 8'h08
`define ADDR_COMMAND 8'h0C
`define ADDR_STATUS 8'h10
`define ADDR_MEM_USED 8'h14
`define ADDR_SAMPLE_ADDR 8'h18
`define ADDR_SAMPLE_DATA 8'h1C

// Control bits
`define CTL_LEGACY 0
`define CTL_TWELVE 1
`define CTL_REVERSED 2

// Status bits
`define ST_BUSY 0
`define ST_DEFINE_ERR 1
`define ST_LOAD_ERR 2
`define ST_CMD_ERR 3
`define ST_ARMED_TRACE 4
`define ST_ARMED_TABLE 5

// Command codes, low byte of the command register
`define CMD_DELETE 8'h01
`define CMD_DELETE_ALL 8'h02
`define CMD_ARM_TRACE 8'h03
`define CMD_ARM_TABLE 8'h04

// Memory geometry
`define MEM_WORDS 21'h10_0000
`define MAX_SEGMENTS 15'h4000
`define DEFAULT_SEGMENT 15'h0001
`define MIN_LEN_MODERN 21'h00_0010
`define MIN_LEN_LEGACY 21'h00_000A

// Block framing bytes
`define BLOCK_START 8'h23
`define ASCII_ZERO 8'h30
`define ASCII_NINE 8'h39

// Parser states, one-hot
`define S_IDLE 5'b0_0001
`define S_NDIG 5'b0_0010
`define S_LEN 5'b0_0100
`define S_DATA 5'b0_1000
`define S_CLEAR 5'b1_0000

`define ARM_NONE 2'h0
`define ARM_TRACE 2'h1
`define ARM_TABLE 2'h2

`endif

// >>> wave_memory.v
`timescale 1ns/100ps
`include "wave_loader_defines.vh"

// ****************************************
// Sample memory, one write and one read port
// ****************************************
module wave_memory
(
   input wire clk,
   input wire writeEnable,
   input wire [19:0] writeAddr,
   input wire [15:0] writeData,
   input wire [19:0] readAddr,
   output reg [15:0] readData
);

   reg [15:0] cells [0:1048575];

   always @(posedge clk)
   begin
      if (writeEnable)
      begin
         cells[writeAddr] <= writeData;
      end
      readData <= cells[readAddr];
   end

endmodule

// >>> waveform_segment_loader.v
// Notes on behaviour
// - Block header is '#', one digit count, then that many length digits.
// - Samples are 16-bit words of two bytes; bytes equal twice samples.
// - Block ends on byte with end-or-identify; CR and LF are plain data.
// - Received samples go into the active segment.
// - Full 16-bit codes accepted unchanged; mid code is zero output.
// - 12-bit mode treats codes as 12-bit, with or without legacy; half scale is zero.
// - One mega-point memory, up to 16k segments; overflowing define rejected.
// - Segment length must be a multiple of four, two in legacy 12-bit, else error.
// - Minimum length sixteen, ten in legacy 12-bit; memory caps maximum.
// - Define takes segment 1 to 16k with a length, records size.
// - Deleted non-last segment reload must not exceed deleted size.
// - Deleted last segment reload is limited only by memory size.
// - Delete-all clears table only, sample memory kept for recovery.
// - Select sets active segment, default one; define and sync use it.
// - Segment table block has one four-byte size entry per segment.
// - Table contents are not validated during transfer.
// - Legacy 12-bit format uses two-way interleave instead of four.
// - 12-bit format ignores the four low bits of each word.
// - High byte first by default; reversed order swaps each pair.
`timescale 1ns/100ps
`include "wave_loader_defines.vh"

module waveform_segment_loader
(
   input wire ref_clk,
   input wire reset_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [7:0] hostData,
   input wire hostStrobe,
   input wire hostEoi,
   output reg [14:0] syncSegment
);

   // ****************************************
   // Reset synchroniser
   // ****************************************
   reg [1:0] rstSync;
   wire rstN;
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         rstSync <= 2'b00;
      else
         rstSync <= {rstSync[0], 1'b1};
   end
   assign rstN = rstSync[1];

   function isDigit;
      input [7:0] b;
      begin
         isDigit = (b >= `ASCII_ZERO) && (b <= `ASCII_NINE);
      end
   endfunction

   function regHit;
      input [7:0] a;
      input [7:0] target;
      begin
         regHit = (a == target);
      end
   endfunction

   // ****************************************
   // State and segment table
   // ****************************************
   reg legacy;
   reg twelveBit;
   reg reversedOrder;
   reg [14:0] activeSeg;
   reg [19:0] sampleAddr;
   reg defineErr;
   reg loadErr;
   reg cmdErr;
   reg [1:0] armed;
   reg [1:0] blockKind;
   reg [4:0] state;
   reg [3:0] digitsLeft;
   reg [31:0] byteCount;
   reg [31:0] bytesSeen;
   reg [7:0] firstByte;
   reg [23:0] entryHigh;
   reg [20:0] wordIdx;
   reg [14:0] tableIdx;
   reg [20:0] running;
   reg [20:0] memTop;
   reg [14:0] lastSeg;
   reg [14:0] clearIdx;
   reg [19:0] segStart [0:16384];
   reg [20:0] segLen [0:16384];
   reg [20:0] segCap [0:16384];

   wire legacy12 = legacy & twelveBit;
   wire apbWrite = psel & penable & pready & pwrite;
   wire byteIn = hostStrobe & (state == `S_DATA);

   // ****************************************
   // Define checks
   // ****************************************
   wire [20:0] defLen = pwdata[20:0];
   wire [20:0] minLen = legacy12 ? `MIN_LEN_LEGACY : `MIN_LEN_MODERN;
   wire stepOk = legacy12 ? ~defLen[0] : (defLen[1:0] == 2'b00);
   wire segOk = (activeSeg != 15'h0000) && (activeSeg <= `MAX_SEGMENTS);
   wire [20:0] curCap = segCap[activeSeg];
   wire [19:0] curStart = segStart[activeSeg];
   wire [21:0] endIfLast = {2'b00, curStart} + {1'b0, defLen};
   wire [21:0] endIfNew = {1'b0, memTop} + {1'b0, defLen};
   wire isOld = (curCap != 21'h00_0000);
   wire isLast = isOld && (activeSeg == lastSeg);
   wire fitOk = isLast ? (endIfLast <= {1'b0, `MEM_WORDS}) :
                isOld ? (defLen <= curCap) :
                (endIfNew <= {1'b0, `MEM_WORDS});
   wire defineOk = segOk && stepOk && (defLen >= minLen) &&
                   (defLen <= `MEM_WORDS) && fitOk;

   // ****************************************
   // Byte stream decoding
   // ****************************************
   wire [7:0] hiByte = reversedOrder ? hostData : firstByte;
   wire [7:0] loByte = reversedOrder ? firstByte : hostData;
   wire [15:0] rawWord = {hiByte, loByte};
   wire [15:0] sampleWord = twelveBit ? {rawWord[15:4], 4'h0} : rawWord;
   wire [31:0] entryWord = {entryHigh, hostData};
   wire [21:0] sampleAddrSum = {2'b00, segStart[activeSeg]} + {1'b0, wordIdx};
   wire inSeg = wordIdx < segLen[activeSeg];
   wire wantBytes = bytesSeen < byteCount;
   wire wordDone = byteIn && bytesSeen[0] && wantBytes &&
                   (blockKind == `ARM_TRACE);
   wire memWrite = wordDone && inSeg;
   wire [31:0] countTimesTen = {byteCount[28:0], 3'b000} +
                               {byteCount[30:0], 1'b0};
   wire [15:0] memRead;

   wave_memory memory
   (
      .clk(ref_clk),
      .writeEnable(memWrite),
      .writeAddr(sampleAddrSum[19:0]),
      .writeData(sampleWord),
      .readAddr(sampleAddr),
      .readData(memRead)
   );

   // ****************************************
   // Parser, table and register writes
   // ****************************************
   always @(posedge ref_clk or negedge rstN)
   begin
      if (!rstN)
      begin
         legacy <= 1'b0;
         twelveBit <= 1'b0;
         reversedOrder <= 1'b0;
         activeSeg <= `DEFAULT_SEGMENT;
         sampleAddr <= 20'h0_0000;
         defineErr <= 1'b0;
         loadErr <= 1'b0;
         cmdErr <= 1'b0;
         armed <= `ARM_NONE;
         blockKind <= `ARM_NONE;
         state <= `S_CLEAR;
         digitsLeft <= 4'h0;
         byteCount <= 32'h0000_0000;
         bytesSeen <= 32'h0000_0000;
         firstByte <= 8'h00;
         entryHigh <= 24'h00_0000;
         wordIdx <= 21'h00_0000;
         tableIdx <= 15'h0001;
         running <= 21'h00_0000;
         memTop <= 21'h00_0000;
         lastSeg <= 15'h0000;
         clearIdx <= 15'h0000;
      end
      else
      begin
         // Clear first so any set below wins
         if (apbWrite && regHit(paddr, `ADDR_STATUS) && pwdata[`ST_LOAD_ERR])
            loadErr <= 1'b0;
         case (state)
            `S_IDLE:
            begin
               if (hostStrobe && hostData == `BLOCK_START &&
                   armed != `ARM_NONE)
               begin
                  blockKind <= armed;
                  armed <= `ARM_NONE;
                  state <= `S_NDIG;
               end
            end
            `S_NDIG:
            begin
               if (hostStrobe)
               begin
                  if (isDigit(hostData) && hostData != `ASCII_ZERO)
                  begin
                     digitsLeft <= hostData[3:0];
                     byteCount <= 32'h0000_0000;
                     state <= `S_LEN;
                  end
                  else
                  begin
                     loadErr <= 1'b1;
                     state <= `S_IDLE;
                  end
               end
            end
            `S_LEN:
            begin
               if (hostStrobe)
               begin
                  if (isDigit(hostData))
                  begin
                     byteCount <= countTimesTen + {28'h000_0000, hostData[3:0]};
                     digitsLeft <= digitsLeft - 4'h1;
                     if (digitsLeft == 4'h1)
                     begin
                        bytesSeen <= 32'h0000_0000;
                        wordIdx <= 21'h00_0000;
                        tableIdx <= 15'h0001;
                        running <= 21'h00_0000;
                        state <= `S_DATA;
                     end
                  end
                  else
                  begin
                     loadErr <= 1'b1;
                     state <= `S_IDLE;
                  end
               end
            end
            `S_DATA:
            begin
               if (byteIn)
               begin
                  // CR and LF are counted as data here
                  if (wantBytes)
                  begin
                     bytesSeen <= bytesSeen + 32'h0000_0001;
                     firstByte <= hostData;
                     entryHigh <= entryWord[23:0];
                  end
                  if (wordDone)
                  begin
                     wordIdx <= wordIdx + 21'h00_0001;
                     if (!inSeg)
                        loadErr <= 1'b1;
                  end
                  if (wantBytes && blockKind == `ARM_TABLE &&
                      bytesSeen[1:0] == 2'b11)
                  begin
                     // Entries taken as sent, no range checks
                     segStart[tableIdx] <= running[19:0];
                     segLen[tableIdx] <= entryWord[20:0];
                     segCap[tableIdx] <= entryWord[20:0];
                     running <= running + entryWord[20:0];
                     tableIdx <= tableIdx + 15'h0001;
                  end
                  if (hostEoi)
                  begin
                     if (bytesSeen + 32'h0000_0001 != byteCount)
                        loadErr <= 1'b1;
                     if (blockKind == `ARM_TABLE)
                     begin
                        memTop <= (wantBytes && bytesSeen[1:0] == 2'b11) ?
                                  running + entryWord[20:0] : running;
                        lastSeg <= (wantBytes && bytesSeen[1:0] == 2'b11) ?
                                   tableIdx : tableIdx - 15'h0001;
                     end
                     state <= `S_IDLE;
                  end
               end
            end
            `S_CLEAR:
            begin
               // Table only; samples stay for recovery
               segLen[clearIdx] <= 21'h00_0000;
               segCap[clearIdx] <= 21'h00_0000;
               segStart[clearIdx] <= 20'h0_0000;
               clearIdx <= clearIdx + 15'h0001;
               if (clearIdx == `MAX_SEGMENTS)
               begin
                  memTop <= 21'h00_0000;
                  lastSeg <= 15'h0000;
                  state <= `S_IDLE;
               end
            end
            default:
               state <= `S_IDLE;
         endcase

         if (apbWrite)
         begin
            if (regHit(paddr, `ADDR_CONTROL))
            begin
               legacy <= pwdata[`CTL_LEGACY];
               twelveBit <= pwdata[`CTL_TWELVE];
               reversedOrder <= pwdata[`CTL_REVERSED];
            end
            if (regHit(paddr, `ADDR_SELECT))
               activeSeg <= pwdata[14:0];
            if (regHit(paddr, `ADDR_SAMPLE_ADDR))
               sampleAddr <= pwdata[19:0];
            if (regHit(paddr, `ADDR_STATUS))
            begin
               // Hardware set wins over clear in the same cycle
               if (pwdata[`ST_DEFINE_ERR])
                  defineErr <= 1'b0;
               if (pwdata[`ST_CMD_ERR])
                  cmdErr <= 1'b0;
            end
            if (regHit(paddr, `ADDR_DEFINE))
            begin
               if (!defineOk || state != `S_IDLE)
                  defineErr <= 1'b1;
               else
               begin
                  segLen[activeSeg] <= defLen;
                  if (isLast)
                  begin
                     segCap[activeSeg] <= defLen;
                     memTop <= endIfLast[20:0];
                  end
                  else if (!isOld)
                  begin
                     segStart[activeSeg] <= memTop[19:0];
                     segCap[activeSeg] <= defLen;
                     memTop <= endIfNew[20:0];
                     lastSeg <= activeSeg;
                  end
               end
            end
            if (regHit(paddr, `ADDR_COMMAND))
            begin
               if (state != `S_IDLE)
                  cmdErr <= 1'b1;
               else
               begin
                  case (pwdata[7:0])
                     `CMD_DELETE:
                        segLen[pwdata[30:16]] <= 21'h00_0000;
                     `CMD_DELETE_ALL:
                     begin
                        clearIdx <= 15'h0000;
                        state <= `S_CLEAR;
                     end
                     `CMD_ARM_TRACE:
                        armed <= `ARM_TRACE;
                     `CMD_ARM_TABLE:
                        armed <= `ARM_TABLE;
                     default:
                        cmdErr <= 1'b1;
                  endcase
               end
            end
         end
      end
   end

   // ****************************************
   // APB answer and sync output
   // ****************************************
   reg [31:0] next_prdata;
   reg next_pslverr;
   always @*
   begin
      next_prdata = 32'h0000_0000;
      next_pslverr = 1'b0;
      case (paddr)
         `ADDR_CONTROL:
            next_prdata = {29'h0000_0000, reversedOrder, twelveBit, legacy};
         `ADDR_SELECT:
            next_prdata = {17'h0_0000, activeSeg};
         `ADDR_DEFINE:
            next_prdata = {11'h000, segLen[activeSeg]};
         `ADDR_COMMAND:
            next_prdata = 32'h0000_0000;
         `ADDR_STATUS:
            next_prdata = {26'h000_0000, armed == `ARM_TABLE,
                           armed == `ARM_TRACE, cmdErr, loadErr, defineErr,
                           state != `S_IDLE};
         `ADDR_MEM_USED:
            next_prdata = {11'h000, memTop};
         `ADDR_SAMPLE_ADDR:
            next_prdata = {12'h000, sampleAddr};
         `ADDR_SAMPLE_DATA:
            next_prdata = {16'h0000, memRead};
         default:
            next_pslverr = 1'b1;
      endcase
   end

   always @(posedge ref_clk or negedge rstN)
   begin
      if (!rstN)
      begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
         syncSegment <= `DEFAULT_SEGMENT;
      end
      else
      begin
         pready <= psel & penable & ~pready;
         prdata <= (psel & penable & ~pready & ~pwrite) ?
                   next_prdata : 32'h0000_0000;
         pslverr <= psel & penable & ~pready & next_pslverr;
         syncSegment <= activeSeg;
      end
   end

endmodule

// >>> waveform_segment_loader_chk.sv
`timescale 1ns/100ps
module waveform_segment_loader_chk
(
   input wire ref_clk,
   input wire reset_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire [14:0] syncSegment
);
   wire access = psel && penable;
   wire selWr = access && pready && pwrite && paddr == 8'h04;
   wire mapped = paddr <= 8'h1C && paddr[1:0] == 2'b00;
   wire selLegal = pwdata[14:0] != 0 && pwdata[14:0] <= 15'h4000;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // ****************************************
   // Register bus timing
   // ****************************************
   sequence accessOpens;
      psel && $rose(penable);
   endsequence
   sequence oneWait;
      !pready ##1 pready;
   endsequence
   AST_ONE_WAIT: assert property (accessOpens |-> oneWait)
      else $error("pready not after exactly one wait");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   AST_READY_IN_ACCESS: assert property (pready |-> access)
      else $error("pready outside access phase");
   AST_ERR_UNMAPPED: assert property (access && pready |-> pslverr == !mapped)
      else $error("pslverr does not match address map");
   AST_ERR_ONLY_READY: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   AST_RDATA_QUIET: assert property (!pready || pslverr |-> prdata == 0)
      else $error("prdata not zero outside a good read");
   // ****************************************
   // Active segment marker
   // ****************************************
   AST_SYNC_RESET: assert property (
      $rose(reset_n) |-> syncSegment == 1)
      else $error("active segment not one after reset");
   AST_SYNC_SELECT: assert property (selWr && selLegal |-> ##2
      syncSegment == $past(pwdata[14:0], 2))
      else $error("marker does not follow selection");
   AST_SYNC_HOLD: assert property (
      !selWr |-> ##2 $stable(syncSegment))
      else $error("marker moved without selection");
endmodule
bind waveform_segment_loader waveform_segment_loader_chk i_chk
(
   .ref_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .syncSegment
);

// >>> waveform_segment_loader_test.sv
`timescale 1ns/100ps
`include "wave_loader_defines.vh"
`define CHK(n, e, s) \
   begin \
      testsRun++; \
      if ((s) !== (e)) \
      begin \
         numErrors++; \
         $display("MISMATCH %s exp %h got %h", n, e, s); \
      end \
   end
module waveform_segment_loader_test;
   typedef struct {int kind; int seg; int len; int cap;} step_t;
   localparam int M = 1048576;
   reg ref_clk = 1'b0;
   reg reset_n = 1'b0;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [7:0] paddr = 8'h00;
   reg [31:0] pwdata = 32'h0000_0000;
   wire [31:0] prdata;
   wire pready;
   wire pslverr;
   wire [7:0] hostData;
   wire hostStrobe;
   wire hostEoi;
   wire [14:0] syncSegment;
   reg [31:0] rd;
   reg errSeen;
   integer numErrors = 0;
   integer testsRun = 0;
   integer seed = 32'h2e8e;
   int segLen[int];
   logic [15:0] kept[2];
   bit leg;
   step_t steps[15] = '{'{2, 0, 3, 0}, '{0, 1, 9, M}, '{0, 1, 10, M},
      '{2, 0, 0, 0}, '{0, 1, 18, M}, '{0, 1, 12, M}, '{0, 1, 16, M},
      '{0, 2, 20, M - 16}, '{0, 3, M - 32, M - 36}, '{0, 3, 100, M - 36},
      '{1, 1, 0, 0}, '{0, 1, 20, 16}, '{0, 1, 16, 16}, '{1, 3, 0, 0},
      '{0, 3, M - 36, M - 36}};
   always #50 ref_clk = ~ref_clk;
   waveform_segment_loader i_dut
   (
      .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .hostData(hostData), .hostStrobe(hostStrobe),
      .hostEoi(hostEoi), .syncSegment(syncSegment)
   );
   host_block_source i_host
   (
      .ref_clk(ref_clk), .hostData(hostData), .hostStrobe(hostStrobe),
      .hostEoi(hostEoi)
   );
   task automatic apb(input bit wr, input [7:0] a, input [31:0] d);
      begin
         psel <= 1'b1;
         pwrite <= wr;
         paddr <= a;
         pwdata <= d;
         @(posedge ref_clk);
         penable <= 1'b1;
         do
         begin
            @(posedge ref_clk);
         end
         while (pready !== 1'b1);
         rd = prdata;
         errSeen = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge ref_clk);
      end
   endtask
   task automatic waitIdle;
      begin
         do
            apb(0, `ADDR_STATUS, 0);
         while (rd[0] !== 1'b0);
         `CHK("busy", 1'b0, rd[0])
      end
   endtask
   task automatic status(input [3:0] exp);
      begin
         apb(0, `ADDR_STATUS, 0);
         `CHK("status", exp, rd[3:0])
         apb(1, `ADDR_STATUS, 32'h0000_000E);
      end
   endtask
   task automatic sample(input int a, input [15:0] exp);
      begin
         apb(1, `ADDR_SAMPLE_ADDR, a);
         apb(0, `ADDR_SAMPLE_DATA, 0);
         `CHK("sample", exp, rd[15:0])
      end
   endtask
   task automatic readLen(input int seg);
      begin
         apb(1, `ADDR_SELECT, seg);
         apb(0, `ADDR_DEFINE, 0);
         `CHK("sync", seg[14:0], syncSegment)
         `CHK("length", 21'(segLen[seg]), rd[20:0])
      end
   endtask
   task automatic runStep(input step_t s);
      bit ok;
      begin
         if (s.kind == 2)
         begin
            apb(1, `ADDR_CONTROL, s.len);
            leg = s.len == 3;
         end
         else if (s.kind == 1)
         begin
            apb(1, `ADDR_COMMAND, {1'b0, s.seg[14:0], 16'h0001});
            status(4'h0);
            segLen.delete(s.seg);
         end
         else
         begin
            apb(1, `ADDR_SELECT, s.seg);
            apb(1, `ADDR_DEFINE, s.len);
            ok = s.len % (leg ? 2 : 4) == 0;
            ok = ok && s.len <= s.cap;
            ok = ok && s.len >= (leg ? 10 : 16);
            status({2'b00, !ok, 1'b0});
            if (ok)
            begin
               segLen[s.seg] = s.len;
               readLen(s.seg);
            end
         end
      end
   endtask
   task automatic loadTrace(input [31:0] ctl);
      logic [7:0] b[$];
      logic [15:0] w;
      begin
         apb(1, `ADDR_CONTROL, ctl);
         apb(1, `ADDR_COMMAND, 32'h0000_0003);
         b = {8'h0D, 8'h0A, 8'($random(seed)), 8'($random(seed))};
         i_host.sendBlock(b);
         status(4'h0);
         for (int k = 0; k < 2; k++)
         begin
            w = ctl[2] ? {b[2*k+1], b[2*k]} : {b[2*k], b[2*k+1]};
            if (ctl[1])
               w[3:0] = 4'h0;
            kept[k] = w;
            sample(k, w);
         end
      end
   endtask
   task automatic giveVerdict;
      begin
         $display("Checks run %0d, mismatches %0d", testsRun, numErrors);
         if (numErrors == 0 && testsRun > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   initial
   begin
      repeat (50000) @(posedge ref_clk);
      numErrors++;
      giveVerdict;
   end
   initial
   begin
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      `CHK("sync", 15'h0001, syncSegment)
      // Let the reset synchroniser release before the first setup
      repeat (3) @(posedge ref_clk);
      waitIdle;
      apb(0, `ADDR_CONTROL, 0);
      `CHK("control", 32'h0000_0000, rd)
      apb(0, 8'h40, 0);
      `CHK("slverr", 1'b1, errSeen)
      `CHK("prdata", 32'h0000_0000, rd)
      apb(1, `ADDR_COMMAND, 32'h0000_0007);
      status(4'h8);
      foreach (steps[i])
         runStep(steps[i]);
      apb(1, `ADDR_SELECT, 1);
      foreach (steps[i])
         if (i < 4)
            loadTrace(i * 2);
      apb(1, `ADDR_COMMAND, 32'h0000_0002);
      apb(0, `ADDR_STATUS, 0);
      `CHK("busy", 1'b1, rd[0])
      waitIdle;
      status(4'h0);
      sample(0, kept[0]);
      apb(1, `ADDR_COMMAND, 32'h0000_0004);
      i_host.sendBlock({8'h00, 8'h00, 8'h00, 8'h24,
         8'h00, 8'h00, 8'h00, 8'h14});
      status(4'h0);
      segLen[1] = 36;
      segLen[2] = 20;
      readLen(1);
      readLen(2);
      giveVerdict;
   end
endmodule
